// [verilog/tmr_pkg.sv]
// Package with register map, field positions, reset values and timing constants of the timer control block.
package tmr_pkg;
    // =====================================================================
    // Register addresses
    localparam logic [15:0] ADDR_PORT_FIVE_DIRECTION = 16'hFF25;
    localparam logic [15:0] ADDR_CAPTURE_COMPARE_CONTROL = 16'hFF6A;
    localparam logic [15:0] ADDR_TIMER_OUTPUT_CONTROL = 16'hFF6B;
    localparam logic [15:0] ADDR_MODE_CONTROL = 16'hFF7E;
    localparam logic [15:0] ADDR_PRESCALER_MODE = 16'hFF7F;
    localparam logic [15:0] ADDR_REG_A = 16'hFF16;
    localparam logic [15:0] ADDR_REG_B = 16'hFF18;
    localparam logic [15:0] ADDR_COUNT = 16'hFF10;
    // =====================================================================
    // Reset values
    localparam logic [7:0] RST_PORT_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    // =====================================================================
    // Field positions
    localparam int CCC_REGA_CAP = 0;
    localparam int CCC_REGA_TRIG = 1;
    localparam int CCC_REGB_CAP = 2;
    localparam int TOC_PIN_EN = 0;
    localparam int TOC_TOG_A = 1;
    localparam int TOC_CLR = 2;
    localparam int TOC_SET = 3;
    localparam int TOC_TOG_B = 4;
    localparam int TOC_OS_EN = 5;
    localparam int TOC_OS_TRIG = 6;
    localparam int MOD_OVF = 0;
    localparam int MOD_B0 = 1;
    localparam int MOD_B1 = 2;
    localparam int MOD_B2 = 3;
    localparam int PRM_CLK_LO = 0;
    localparam int PRM_E0_LO = 4;
    localparam int PRM_E1_LO = 6;
    localparam int PIN_SHARED_IN = 3;
    localparam int PIN_SHARED_OUT = 4;
    localparam logic [7:0] CCC_MASK = 8'h07;
    localparam logic [7:0] TOC_READ_MASK = 8'h33;
    localparam logic [7:0] MOD_MASK = 8'h0F;
    localparam logic [7:0] PRM_MASK = 8'hF3;
    // =====================================================================
    // Encodings
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV256 = 2'h2;
    localparam logic [1:0] OPM_STOP = 2'h0;
    localparam logic [1:0] OPM_FREE = 2'h1;
    localparam logic [1:0] OPM_CLR_EDGE = 2'h2;
    localparam logic [1:0] OPM_CLR_MATCH = 2'h3;
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [DIV_W-1:0] DIV2_LAST = 8'h01;
    localparam logic [DIV_W-1:0] DIV4_LAST = 8'h03;
    localparam logic [DIV_W-1:0] DIV256_LAST = 8'hFF;
endpackage

// [verilog/edge_sense_if.sv]
// Interface carrying one synchronised timer input and its edge decisions.
`timescale 1ns/1ps
interface edge_sense_if;
    logic [1:0] edge_sel;
    logic arm;
    logic sample_en;
    logic level;
    logic valid_edge;
    logic reverse_edge;
    modport sense
    (
        input edge_sel,
        input arm,
        input sample_en,
        output level,
        output valid_edge,
        output reverse_edge
    );
    modport user
    (
        output edge_sel,
        output arm,
        output sample_en,
        input level,
        input valid_edge,
        input reverse_edge
    );
endinterface

// [verilog/edge_sense.sv]
// Pin synchroniser with two-sample noise filter and edge classifier.
`timescale 1ns/1ps
module edge_sense
    import tmr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Raw pin.
    input wire logic pin_in,
    // Decisions.
    edge_sense_if.sense es
);
    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic filt_ff;
    logic nxt_filt;
    logic prev_ff;
    logic nxt_prev;
    logic first_ff;
    logic nxt_first;
    logic agree;
    logic rise;
    logic fall;

    // =====================================================================
    // Sampling
    always_comb
    begin
        nxt_sync = {sync_ff[1:0], pin_in};
        agree = (sync_ff[1] == sync_ff[2]);
        nxt_filt = filt_ff;
        nxt_prev = prev_ff;
        nxt_first = first_ff;
        if (es.sample_en && agree)
        begin
            nxt_filt = sync_ff[2];
        end
        if (es.sample_en)
        begin
            // Before the first start the stored level stays low, so a high pin after reset gives one rising edge.
            if (es.arm || !first_ff)
            begin
                nxt_prev = es.arm ? filt_ff : nxt_filt;
            end
            if (es.arm)
            begin
                nxt_first = 1'b0;
            end
        end
        rise = es.sample_en && es.arm && filt_ff && !prev_ff;
        fall = es.sample_en && es.arm && !filt_ff && prev_ff;
        case (es.edge_sel)
            EDGE_FALL: es.valid_edge = fall;
            EDGE_RISE: es.valid_edge = rise;
            EDGE_BOTH: es.valid_edge = rise || fall;
            default: es.valid_edge = 1'b0;
        endcase
        case (es.edge_sel)
            EDGE_FALL: es.reverse_edge = rise;
            EDGE_RISE: es.reverse_edge = fall;
            default: es.reverse_edge = 1'b0;
        endcase
    end

    assign es.level = filt_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            sync_ff <= 3'h0;
            filt_ff <= 1'b0;
            prev_ff <= 1'b0;
            first_ff <= 1'b1;
        end
        else
        begin
            sync_ff <= nxt_sync;
            filt_ff <= nxt_filt;
            prev_ff <= nxt_prev;
            first_ff <= nxt_first;
        end
    end
endmodule

// [verilog/timer_capture_compare_control.sv]
// Top of the 16-bit timer capture/compare control block with its memory-mapped registers.
// =========================================================================
// Summary of operation
// - Capture/compare control resets to zero; only three low bits exist.
// - Register B mode bit picks compare (0) or capture (1).
// - Register A mode bit picks compare (0) or capture (1).
// - Register A capture trigger: second input edge, or first input reverse edge.
// - Reverse-phase capture is suppressed when first input uses both edges.
// - One-shot trigger bit starts a pulse, self-clears, reads zero.
// - One-shot mode works in free-running and clear-on-edge modes only.
// - Separate enables let matches with A or B toggle the output.
// - Set/clear pair: 01 clears, 10 sets, 11 prohibited; both read zero.
// - Output enable low holds pin at zero, else flip-flop drives.
// - Each input edge field: 00 fall, 01 rise, 11 both.
// - Count clock is osc/2, osc/4, osc/256 or first input edge.
// - High input after reset gives one rising edge on first start only.
// - Port direction resets to all ones; zero enables the output buffer.
// - Mode field: stop held at zero, free, clear on edge, clear on A match.
// - Counting starts when upper mode bits nonzero, stops when both zero.
`timescale 1ns/1ps
module timer_capture_compare_control
    import tmr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Memory access.
    input wire logic [15:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_wr16,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    // Timer pins.
    input wire logic first_timer_input,
    input wire logic second_timer_input,
    output logic timer_output_pin,
    output logic [7:0] port_pin_output_enable,
    // Events.
    output logic match_a_irq,
    output logic match_b_irq
);
    import tmr_pkg::*;

    logic [7:0] dir_ff, nxt_dir;
    logic [2:0] ccc_ff, nxt_ccc;
    logic [5:0] toc_ff, nxt_toc;
    logic [3:0] mod_ff, nxt_mod;
    logic [7:0] prm_ff, nxt_prm;
    logic [15:0] rega_ff, nxt_rega;
    logic [15:0] regb_ff, nxt_regb;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic out_ff, nxt_out;
    logic os_pend_ff, nxt_os_pend;
    logic os_active_ff, nxt_os_active;
    logic ma_ff, nxt_ma;
    logic mb_ff, nxt_mb;
    logic pin_ff, nxt_pin;
    logic [15:0] rd_ff, nxt_rd;
    logic [DIV_W-1:0] div_last;
    logic tick;
    logic [1:0] opm;
    logic running;
    logic w8;
    logic hit_a;
    logic hit_b;
    logic cap_a;
    logic cap_b;
    logic clr_start;
    logic ovf;

    edge_sense_if e0 ();
    edge_sense_if e1 ();

    edge_sense u_edge0
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in(first_timer_input),
        .es(e0.sense)
    );
    edge_sense u_edge1
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in(second_timer_input),
        .es(e1.sense)
    );

    // =====================================================================
    // Count clock
    // The count clock is an enable, so all state stays on clk_sys and no derived clock needs constraints.
    always_comb
    begin
        case (prm_ff[PRM_CLK_LO +: 2])
            CLK_DIV2: div_last = DIV2_LAST;
            CLK_DIV4: div_last = DIV4_LAST;
            CLK_DIV256: div_last = DIV256_LAST;
            default: div_last = DIV2_LAST;
        endcase
        nxt_div = (div_ff >= div_last) ? RST_ZERO8 : div_ff + DIV_ONE;
        if (prm_ff[PRM_CLK_LO +: 2] == 2'h3)
        begin
            tick = e0.valid_edge;
        end
        else
        begin
            tick = (div_ff >= div_last);
        end
    end

    assign opm = mod_ff[MOD_B2 -: 2];
    assign running = (opm != OPM_STOP);
    // External count mode samples the first input every main clock; otherwise, and always for the second input, on the count clock.
    assign e0.sample_en = (prm_ff[PRM_CLK_LO +: 2] == 2'h3) ? 1'b1 : tick;
    assign e1.sample_en = tick;
    assign e0.arm = running;
    assign e1.arm = running;
    assign e0.edge_sel = prm_ff[PRM_E0_LO +: 2];
    assign e1.edge_sel = prm_ff[PRM_E1_LO +: 2];

    // =====================================================================
    // Counter, captures and output
    always_comb
    begin
        w8 = mem_wr && !mem_wr16;
        nxt_dir = dir_ff;
        nxt_ccc = ccc_ff;
        nxt_toc = toc_ff;
        nxt_mod = mod_ff;
        nxt_prm = prm_ff;
        nxt_rega = rega_ff;
        nxt_regb = regb_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        nxt_os_pend = os_pend_ff;
        nxt_os_active = os_active_ff;
        nxt_ma = 1'b0;
        nxt_mb = 1'b0;
        ovf = 1'b0;
        hit_a = running && tick && !ccc_ff[CCC_REGA_CAP] && (cnt_ff == rega_ff);
        hit_b = running && tick && !ccc_ff[CCC_REGB_CAP] && (cnt_ff == regb_ff);
        cap_b = running && ccc_ff[CCC_REGB_CAP] && e0.valid_edge;
        if (ccc_ff[CCC_REGA_TRIG])
        begin
            cap_a = running && ccc_ff[CCC_REGA_CAP] && e0.reverse_edge;
        end
        else
        begin
            cap_a = running && ccc_ff[CCC_REGA_CAP] && e1.valid_edge;
        end
        clr_start = (opm == OPM_CLR_EDGE) && e0.valid_edge;
        if (!running)
        begin
            nxt_cnt = RST_ZERO16;
            nxt_os_active = 1'b0;
            nxt_os_pend = 1'b0;
        end
        else if (clr_start || (os_pend_ff && tick))
        begin
            nxt_cnt = RST_ZERO16;
            if (os_pend_ff && tick)
            begin
                nxt_os_pend = 1'b0;
                nxt_os_active = 1'b1;
            end
        end
        else if (tick)
        begin
            if ((opm == OPM_CLR_MATCH) && (cnt_ff == rega_ff))
            begin
                nxt_cnt = RST_ZERO16;
                ovf = (rega_ff == COUNT_MAX);
            end
            else
            begin
                nxt_cnt = cnt_ff + COUNT_ONE;
                ovf = (cnt_ff == COUNT_MAX);
            end
        end
        if (cap_a)
        begin
            nxt_rega = cnt_ff;
        end
        if (cap_b)
        begin
            nxt_regb = cnt_ff;
        end
        nxt_ma = hit_a || cap_a;
        nxt_mb = hit_b || cap_b;
        // Output flip-flop: in one-shot mode toggles only while a shot is active.
        if ((hit_a && toc_ff[TOC_TOG_A]) || (hit_b && toc_ff[TOC_TOG_B])
            || (mod_ff[MOD_B0] && running && e0.valid_edge))
        begin
            if (!toc_ff[TOC_OS_EN] || os_active_ff)
            begin
                nxt_out = !out_ff;
            end
        end
        if (toc_ff[TOC_OS_EN] && os_active_ff && hit_a && opm != OPM_CLR_MATCH)
        begin
            nxt_os_active = 1'b0;
        end
        if (ovf)
        begin
            nxt_mod[MOD_OVF] = 1'b1;
        end
        // Register writes; the hardware overflow set wins over a software clear.
        if (w8)
        begin
            case (mem_addr)
                ADDR_PORT_FIVE_DIRECTION: nxt_dir = mem_wdata[7:0];
                ADDR_CAPTURE_COMPARE_CONTROL: nxt_ccc = mem_wdata[2:0];
                ADDR_TIMER_OUTPUT_CONTROL:
                begin
                    nxt_toc = {mem_wdata[TOC_OS_EN], mem_wdata[TOC_TOG_B], 2'h0,
                               mem_wdata[TOC_TOG_A], mem_wdata[TOC_PIN_EN]};
                    if (mem_wdata[TOC_SET] && !mem_wdata[TOC_CLR])
                    begin
                        nxt_out = 1'b1;
                    end
                    else if (mem_wdata[TOC_CLR] && !mem_wdata[TOC_SET])
                    begin
                        nxt_out = 1'b0;
                    end
                    if (mem_wdata[TOC_OS_TRIG] && mem_wdata[TOC_OS_EN] && running)
                    begin
                        nxt_os_pend = 1'b1;
                    end
                end
                ADDR_MODE_CONTROL: nxt_mod = {mem_wdata[3:1], mem_wdata[MOD_OVF] | ovf};
                ADDR_PRESCALER_MODE: nxt_prm = mem_wdata[7:0] & PRM_MASK;
                default: nxt_dir = dir_ff;
            endcase
        end
        if (mem_wr && mem_wr16)
        begin
            if (mem_addr == ADDR_REG_A && !cap_a)
            begin
                nxt_rega = mem_wdata;
            end
            if (mem_addr == ADDR_REG_B && !cap_b)
            begin
                nxt_regb = mem_wdata;
            end
        end
        case (mem_addr)
            ADDR_PORT_FIVE_DIRECTION: nxt_rd = {8'h00, dir_ff};
            ADDR_CAPTURE_COMPARE_CONTROL: nxt_rd = {8'h00, {5'h00, ccc_ff} & CCC_MASK};
            ADDR_TIMER_OUTPUT_CONTROL: nxt_rd = {8'h00, {2'h0, toc_ff} & TOC_READ_MASK};
            ADDR_MODE_CONTROL: nxt_rd = {8'h00, {4'h0, mod_ff} & MOD_MASK};
            ADDR_PRESCALER_MODE: nxt_rd = {8'h00, prm_ff};
            ADDR_REG_A: nxt_rd = rega_ff;
            ADDR_REG_B: nxt_rd = regb_ff;
            ADDR_COUNT: nxt_rd = cnt_ff;
            default: nxt_rd = RST_ZERO16;
        endcase
        nxt_pin = toc_ff[TOC_PIN_EN] ? nxt_out : 1'b0;
    end

    // Toc register packs bits 5,4,1,0 into positions 5,4,1,0; bits 3,2 stay zero.
    assign mem_rdata = rd_ff;
    assign timer_output_pin = pin_ff;
    assign port_pin_output_enable = ~dir_ff;
    assign match_a_irq = ma_ff;
    assign match_b_irq = mb_ff;

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            dir_ff <= RST_PORT_DIR;
            ccc_ff <= 3'h0;
            toc_ff <= 6'h00;
            mod_ff <= 4'h0;
            prm_ff <= RST_ZERO8;
            rega_ff <= RST_ZERO16;
            regb_ff <= RST_ZERO16;
            cnt_ff <= RST_ZERO16;
            div_ff <= RST_ZERO8;
            out_ff <= 1'b0;
            os_pend_ff <= 1'b0;
            os_active_ff <= 1'b0;
            ma_ff <= 1'b0;
            mb_ff <= 1'b0;
            pin_ff <= 1'b0;
            rd_ff <= RST_ZERO16;
        end
        else
        begin
            dir_ff <= nxt_dir;
            ccc_ff <= nxt_ccc;
            toc_ff <= nxt_toc;
            mod_ff <= nxt_mod;
            prm_ff <= nxt_prm;
            rega_ff <= nxt_rega;
            regb_ff <= nxt_regb;
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            out_ff <= nxt_out;
            os_pend_ff <= nxt_os_pend;
            os_active_ff <= nxt_os_active;
            ma_ff <= nxt_ma;
            mb_ff <= nxt_mb;
            pin_ff <= nxt_pin;
            rd_ff <= nxt_rd;
        end
    end
endmodule

// [sim/tmr_pin_partner.sv]
// Model of the pulse sources that drive the two timer input pins.
`timescale 1ns/1ps
module tmr_pin_partner
(
    // Clock.
    input wire logic clk_sys,
    // Pulse requests.
    input wire logic pulse_go,
    input wire logic pulse_sel,
    // Pins.
    output logic first_timer_input,
    output logic second_timer_input
);
    // =====================================================================
    // Pulse generator.
    // Eight system clocks is four count clocks at the fastest rate, so the filter sees two agreeing samples.
    localparam int PULSE_LEN = 8;
    int left = 0;
    logic sel_q = 1'h0;
    always @(posedge clk_sys)
    begin
        if (pulse_go)
        begin
            left <= PULSE_LEN;
            sel_q <= pulse_sel;
        end
        else if (left > 0)
            left <= left - 1;
    end
    // Idle pins rest low, so no stray edge reaches the detector after reset.
    assign first_timer_input = (left > 0) && !sel_q;
    assign second_timer_input = (left > 0) && sel_q;
endmodule

// [sim/tmr_ctrl_asserts.sv]
// Concurrent checks on the ports of the timer capture/compare control block.
`timescale 1ns/1ps
module tmr_ctrl_asserts
    import tmr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Memory access.
    input wire logic [15:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_wr16,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    // Pins and events.
    input wire logic timer_output_pin,
    input wire logic [7:0] port_pin_output_enable,
    input wire logic match_a_irq,
    input wire logic match_b_irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // =====================================================================
    // Shadow copies of the direction register and the output enable bit.
    logic [7:0] dir_ff;
    logic [7:0] nxt_dir;
    logic pen_ff;
    logic nxt_pen;
    logic wr8;
    always_comb
    begin
        wr8 = mem_wr && !mem_wr16;
        nxt_dir = dir_ff;
        nxt_pen = pen_ff;
        if (!rstn)
        begin
            nxt_dir = RST_PORT_DIR;
            nxt_pen = 1'h0;
        end
        else if (wr8 && mem_addr == ADDR_PORT_FIVE_DIRECTION)
            nxt_dir = mem_wdata[7:0];
        else if (wr8 && mem_addr == ADDR_TIMER_OUTPUT_CONTROL)
            nxt_pen = mem_wdata[TOC_PIN_EN];
    end
    always_ff @(posedge clk_sys)
    begin
        dir_ff <= nxt_dir;
        pen_ff <= nxt_pen;
    end
    // =====================================================================
    // Checks.
    sequence toc_wr_s(logic [1:0] sc);
        wr8 && mem_addr == ADDR_TIMER_OUTPUT_CONTROL && pen_ff && mem_wdata[TOC_PIN_EN] && mem_wdata[3:2] == sc;
    endsequence
    reset_clear_a: assert property (
        $rose(rstn) |-> mem_rdata == 16'h0000 && port_pin_output_enable == 8'h00 && !timer_output_pin)
        else $error("outputs not clear after reset");
    dir_map_a: assert property (port_pin_output_enable == ~dir_ff)
        else $error("pin enables do not follow direction");
    dir_read_a: assert property (
        $past(rstn) && $past(mem_addr) == ADDR_PORT_FIVE_DIRECTION && !$past(mem_wr)
        |-> mem_rdata == {8'h00, $past(dir_ff)})
        else $error("direction read wrong");
    ccc_read_a: assert property ($past(mem_addr) == ADDR_CAPTURE_COMPARE_CONTROL |-> mem_rdata[15:3] == 13'h0000)
        else $error("capture control upper bits set");
    toc_read_a: assert property (
        $past(mem_addr) == ADDR_TIMER_OUTPUT_CONTROL |-> (mem_rdata & 16'hFFCC) == 16'h0000)
        else $error("output control write-only bits read");
    irq_a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
        else $error("match a event longer than one cycle");
    irq_b_pulse_a: assert property (match_b_irq |=> !match_b_irq [*2])
        else $error("match b event repeated");
    pin_off_a: assert property (!pen_ff && !$past(pen_ff) |-> !timer_output_pin)
        else $error("output pin high while disabled");
    pin_set_a: assert property (toc_wr_s(2'h2) |-> ##[1:3] timer_output_pin)
        else $error("set did not raise output pin");
    pin_clr_a: assert property (toc_wr_s(2'h1) |-> ##[1:3] !timer_output_pin)
        else $error("clear did not lower output pin");
endmodule
bind timer_capture_compare_control tmr_ctrl_asserts i_chk
(
    .clk_sys(clk_sys),
    .rstn(rstn),
    .mem_addr(mem_addr),
    .mem_wr(mem_wr),
    .mem_wr16(mem_wr16),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .timer_output_pin(timer_output_pin),
    .port_pin_output_enable(port_pin_output_enable),
    .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq)
);

// [sim/timer_capture_compare_control_bench.sv]
// Self-checking bench for the timer capture/compare control block.
`timescale 1ns/1ps
module timer_capture_compare_control_bench;
    import tmr_pkg::*;
    logic clk_sys;
    logic rstn;
    logic [15:0] mem_addr;
    logic mem_wr;
    logic mem_wr16;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic first_timer_input;
    logic second_timer_input;
    logic timer_output_pin;
    logic [7:0] port_pin_output_enable;
    logic match_a_irq;
    logic match_b_irq;
    logic pulse_go;
    logic pulse_sel;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] cap_ccc [4] = '{8'h01, 8'h03, 8'h03, 8'h04};
    logic [7:0] cap_prm [4] = '{8'h40, 8'h10, 8'h30, 8'h10};
    logic cap_pin [4] = '{1'h1, 1'h0, 1'h0, 1'h0};
    logic cap_b [4] = '{1'h0, 1'h0, 1'h0, 1'h1};
    logic cap_exp [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
    timer_capture_compare_control i_dut
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .mem_addr(mem_addr),
        .mem_wr(mem_wr),
        .mem_wr16(mem_wr16),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .first_timer_input(first_timer_input),
        .second_timer_input(second_timer_input),
        .timer_output_pin(timer_output_pin),
        .port_pin_output_enable(port_pin_output_enable),
        .match_a_irq(match_a_irq),
        .match_b_irq(match_b_irq)
    );
    tmr_pin_partner i_pins
    (
        .clk_sys(clk_sys),
        .pulse_go(pulse_go),
        .pulse_sel(pulse_sel),
        .first_timer_input(first_timer_input),
        .second_timer_input(second_timer_input)
    );
    // =====================================================================
    // Clock, timeout and closing report.
    initial
    begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // The whole run needs a little over five hundred cycles; the ceiling leaves ample margin.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    // =====================================================================
    // Bus and compare helpers.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_sys);
        mem_addr <= a;
        mem_wdata <= d;
        mem_wr16 <= w;
        mem_wr <= 1'h1;
        @(posedge clk_sys);
        mem_wr <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_sys);
        mem_addr <= a;
        repeat (2) @(posedge clk_sys);
        #1 chk(what, exp, mem_rdata);
    endtask
    task automatic pin_is(input logic v);
        repeat (3) @(posedge clk_sys);
        #1 chk("output pin", {15'h0000, v}, {15'h0000, timer_output_pin});
    endtask
    task automatic wait_irq(input logic b, input int bound, output logic seen);
        seen = 1'h0;
        repeat (bound)
        begin
            @(posedge clk_sys);
            #1 if ((b ? match_b_irq : match_a_irq) === 1'h1)
            begin
                seen = 1'h1;
                break;
            end
        end
    endtask
    // =====================================================================
    // Scenarios.
    task automatic t_regs();
        rd(ADDR_PORT_FIVE_DIRECTION, 16'h00FF, "direction reset");
        rd(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0000, "capture control reset");
        rd(ADDR_TIMER_OUTPUT_CONTROL, 16'h0000, "output control reset");
        wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h00FF, 1'h0);
        rd(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0007, "capture control bits");
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0061, 1'h0);
        rd(ADDR_TIMER_OUTPUT_CONTROL, 16'h0021, "trigger self clear");
        wr(ADDR_PRESCALER_MODE, 16'h00FF, 1'h0);
        rd(ADDR_PRESCALER_MODE, 16'h00F3, "prescaler bits");
        wr(ADDR_PRESCALER_MODE, 16'h0000, 1'h0);
        wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0000, 1'h0);
        wr(ADDR_PORT_FIVE_DIRECTION, 16'h00E7, 1'h0);
        rd(ADDR_PORT_FIVE_DIRECTION, 16'h00E7, "direction");
        chk("pin enables", 16'h0018, {8'h00, port_pin_output_enable});
        rd(16'h1234, 16'h0000, "unmapped read");
    endtask
    task automatic t_outff();
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0001, 1'h0);
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0009, 1'h0);
        pin_is(1'h1);
        rd(ADDR_TIMER_OUTPUT_CONTROL, 16'h0001, "set bit reads zero");
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0005, 1'h0);
        pin_is(1'h0);
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0009, 1'h0);
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0000, 1'h0);
        pin_is(1'h0);
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0001, 1'h0);
        pin_is(1'h1);
    endtask
    task automatic t_compare();
        logic seen;
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0005, 1'h0);
        wr(ADDR_REG_B, 16'h0005, 1'h1);
        wr(ADDR_REG_A, 16'h0030, 1'h1);
        wr(ADDR_TIMER_OUTPUT_CONTROL, 16'h0011, 1'h0);
        wr(ADDR_MODE_CONTROL, 16'h0004, 1'h0);
        wait_irq(1'h1, 100, seen);
        chk("match b event", 16'h0001, {15'h0000, seen});
        pin_is(1'h1);
        wait_irq(1'h0, 200, seen);
        chk("match a event", 16'h0001, {15'h0000, seen});
        pin_is(1'h1);
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'h0);
        rd(ADDR_COUNT, 16'h0000, "stopped count");
        rd(ADDR_REG_B, 16'h0005, "compare value");
        wr(ADDR_MODE_CONTROL, 16'h000C, 1'h0);
        wait_irq(1'h0, 200, seen);
        wait_irq(1'h0, 200, seen);
        chk("match a repeat", 16'h0001, {15'h0000, seen});
    endtask
    task automatic t_capture();
        logic seen;
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_MODE_CONTROL, 16'h0000, 1'h0);
            wr(ADDR_CAPTURE_COMPARE_CONTROL, {8'h00, cap_ccc[i]}, 1'h0);
            wr(ADDR_PRESCALER_MODE, {8'h00, cap_prm[i]}, 1'h0);
            wr(ADDR_MODE_CONTROL, 16'h0004, 1'h0);
            @(posedge clk_sys);
            pulse_sel <= cap_pin[i];
            pulse_go <= 1'h1;
            @(posedge clk_sys);
            pulse_go <= 1'h0;
            wait_irq(cap_b[i], 80, seen);
            chk("capture event", {15'h0000, cap_exp[i]}, {15'h0000, seen});
        end
        wr(ADDR_MODE_CONTROL, 16'h0000, 1'h0);
    endtask
    initial
    begin
        rstn = 1'h0;
        mem_addr = 16'h0000;
        mem_wr = 1'h0;
        mem_wr16 = 1'h0;
        mem_wdata = 16'h0000;
        pulse_go = 1'h0;
        pulse_sel = 1'h0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'h1;
        t_regs();
        t_outff();
        t_compare();
        t_capture();
        test_done();
    end
endmodule
